// ==== hw/smcg_map.vh ====
// register offsets, field positions, reset values and masks for sleep clock gating
`ifndef SMCG_MAP_VH
`define SMCG_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SMCG_BUS1_OFFSET      8'h50
`define SMCG_BUS2_OFFSET      8'h54
`define SMCG_BUS3_OFFSET      8'h58
`define SMCG_ADDR_WIDTH       8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SMCG_BUS1_RESET       32'h7E6791FF
`define SMCG_BUS2_RESET       32'h000000F1
`define SMCG_BUS3_RESET       32'h00000001

// ----------------------------------------------------------------
// writable bit masks, reserved bits clear
// ----------------------------------------------------------------
`define SMCG_BUS1_MASK        32'h7E6791FF
`define SMCG_BUS2_MASK        32'h000000F3
`define SMCG_BUS3_MASK        32'h00000001

// ----------------------------------------------------------------
// bus1 field positions
// ----------------------------------------------------------------
`define SMCG_B1_PORT_A        0
`define SMCG_B1_PORT_COUNT    9
`define SMCG_B1_CHECKSUM      12
`define SMCG_B1_FLASH_IF      15
`define SMCG_B1_RAM_BANK1     16
`define SMCG_B1_RAM_BANK2     17
`define SMCG_B1_BACKUP_RAM    18
`define SMCG_B1_DMA_UNIT1     21
`define SMCG_B1_DMA_UNIT2     22
`define SMCG_B1_MAC           25
`define SMCG_B1_MAC_TX        26
`define SMCG_B1_MAC_RX        27
`define SMCG_B1_MAC_TS        28
`define SMCG_B1_USB_HS        29
`define SMCG_B1_USB_XCVR      30

// ----------------------------------------------------------------
// bus2 and bus3 field positions
// ----------------------------------------------------------------
`define SMCG_B2_CAMERA        0
`define SMCG_B2_FLOAT         1
`define SMCG_B2_CIPHER        4
`define SMCG_B2_DIGEST        5
`define SMCG_B2_RANDOM        6
`define SMCG_B2_USB_FS        7
`define SMCG_B3_EXT_MEM       0

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define SMCG_RESP_OKAY        2'h0
`define SMCG_RESP_SLVERR      2'h2

`endif

// ==== hw/smcg_enable_reg.v ====
// one sleep clock enable register with byte-lane writes
`timescale 1ns/1ps
module smcg_enable_reg #(
    parameter [31:0] RESET_VALUE = 32'h00000000,
    parameter [31:0] WRITE_MASK  = 32'hFFFFFFFF
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        wr_en,
    input  wire [3:0]  wr_strb,
    input  wire [31:0] wr_data,
    output wire [31:0] value
);

    reg  [31:0] value_reg;
    reg  [31:0] value_next;
    integer     lane;

    // merge strobed bytes, reserved bits forced to zero
    always @* begin
        value_next = value_reg;
        for (lane = 0; lane < 4; lane = lane + 1) begin
            if (wr_en && wr_strb[lane]) begin
                value_next[lane*8 +: 8] = wr_data[lane*8 +: 8];
            end
        end
        value_next = value_next & WRITE_MASK;
    end

    // storage
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule

// ==== hw/smcg_clock_gate.v ====
// latch-free sleep clock gate request for one group of peripherals
`timescale 1ns/1ps
module smcg_clock_gate #(
    parameter WIDTH = 32
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             sleep_active,
    input  wire [WIDTH-1:0] enable_bits,
    output wire [WIDTH-1:0] clk_run
);

    reg  [WIDTH-1:0] snap_reg;
    reg              sleep_d_reg;

    // snapshot enables on sleep entry so mid-sleep writes wait for next entry
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            snap_reg    <= {WIDTH{1'b1}};
            sleep_d_reg <= 1'b0;
        end else begin
            sleep_d_reg <= sleep_active;
            if (sleep_active && !sleep_d_reg) begin
                snap_reg <= enable_bits;
            end
        end
    end

    // run: always when awake, per snapshot while asleep
    assign clk_run = sleep_d_reg ? snap_reg : {WIDTH{1'b1}};

endmodule

// ==== hw/smcg_top.v ====
// sleep mode bus clock gating: three enable registers behind axi4-lite
//
// Contract
// - bus1 register at 0x50: set bit keeps clock in sleep, clear stops it.
// - bus1 register resets to 0x7E6791FF.
// - bus1 bits 0..8 gate ports A..I; bits 11:9 reserved.
// - bus1 checksum 12, flash 15, ram 16/17, backup 18, dma 21/22.
// - bus1 mac clocks: main 25, transmit 26, receive 27, timestamp 28.
// - bus1 usb high-speed 29, transceiver interface 30; bit 31 reserved.
// - bus2 register at 0x54: set bit keeps clock in sleep, clear stops it.
// - bus2 register resets to 0x000000F1.
// - bus2 camera 0, float 1, cipher 4, digest 5, random 6, usb 7.
// - bus3 register at 0x58 bit 0 gates external memory controller.
// - bus3 register resets to 0x00000001.
// - word, half word and byte accesses complete without wait states.
`timescale 1ns/1ps
`include "smcg_map.vh"
module smcg_top (
    input  wire        clk,
    input  wire        reset,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // core sleep indication
    input  wire        sleep_active,
    // bus1 clock run requests
    output wire [8:0]  port_sleep_clk_on,
    output wire        checksum_sleep_clk_on,
    output wire        flash_if_sleep_clk_on,
    output wire        ram_bank1_sleep_clk_on,
    output wire        ram_bank2_sleep_clk_on,
    output wire        backup_ram_sleep_clk_on,
    output wire        dma_unit1_sleep_clk_on,
    output wire        dma_unit2_sleep_clk_on,
    output wire        mac_sleep_clk_on,
    output wire        mac_transmit_sleep_clk_on,
    output wire        mac_receive_sleep_clk_on,
    output wire        mac_timestamp_sleep_clk_on,
    output wire        usb_highspeed_sleep_clk_on,
    output wire        usb_transceiver_if_sleep_clk_on,
    // bus2 clock run requests
    output wire        camera_if_sleep_clk_on,
    output wire        float_unit_sleep_clk_on,
    output wire        cipher_sleep_clk_on,
    output wire        digest_sleep_clk_on,
    output wire        random_source_sleep_clk_on,
    output wire        usb_fullspeed_sleep_clk_on,
    // bus3 clock run request
    output wire        ext_mem_ctrl_sleep_clk_on
);

    // ----------------------------------------------------------------
    // write channel state
    // ----------------------------------------------------------------
    reg  [7:0]  aw_addr_reg;
    reg         aw_held_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_held_reg;
    reg         bvalid_reg;
    reg  [1:0]  bresp_reg;

    // ----------------------------------------------------------------
    // read channel state
    // ----------------------------------------------------------------
    reg         rvalid_reg;
    reg  [31:0] rdata_reg;
    reg  [1:0]  rresp_reg;

    wire        aw_take;
    wire        w_take;
    wire        wr_fire;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        wr_sel1;
    wire        wr_sel2;
    wire        wr_sel3;
    wire        wr_hit;
    wire        ar_take;
    wire [31:0] bus1_value;
    wire [31:0] bus2_value;
    wire [31:0] bus3_value;
    wire [31:0] bus1_run;
    wire [31:0] bus2_run;
    wire [31:0] bus3_run;
    reg  [31:0] rd_value;
    reg         rd_hit;

    // channels accept while empty and no response is pending
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;

    // write fires once both address and data are present, either order
    assign wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take);
    assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;

    assign wr_sel1 = wr_fire && ({wr_addr[7:2], 2'b00} == `SMCG_BUS1_OFFSET);
    assign wr_sel2 = wr_fire && ({wr_addr[7:2], 2'b00} == `SMCG_BUS2_OFFSET);
    assign wr_sel3 = wr_fire && ({wr_addr[7:2], 2'b00} == `SMCG_BUS3_OFFSET);
    assign wr_hit  = wr_sel1 || wr_sel2 || wr_sel3;

    // write address, data and response holding
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_addr_reg <= 8'h00;
            aw_held_reg <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `SMCG_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? `SMCG_RESP_OKAY : `SMCG_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_addr_reg <= s_axi_awaddr;
                    aw_held_reg <= 1'b1;
                end
                if (w_take) begin
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                    w_held_reg <= 1'b1;
                end
                if (bvalid_reg && s_axi_bready) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ----------------------------------------------------------------
    // enable registers
    // ----------------------------------------------------------------
    // bus1 reset and masking
    smcg_enable_reg #(
        .RESET_VALUE (`SMCG_BUS1_RESET),
        .WRITE_MASK  (`SMCG_BUS1_MASK)
    ) u_bus1_reg (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (wr_sel1),
        .wr_strb (wr_strb),
        .wr_data (wr_data),
        .value   (bus1_value)
    );

    smcg_enable_reg #(
        .RESET_VALUE (`SMCG_BUS2_RESET),
        .WRITE_MASK  (`SMCG_BUS2_MASK)
    ) u_bus2_reg (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (wr_sel2),
        .wr_strb (wr_strb),
        .wr_data (wr_data),
        .value   (bus2_value)
    );

    smcg_enable_reg #(
        .RESET_VALUE (`SMCG_BUS3_RESET),
        .WRITE_MASK  (`SMCG_BUS3_MASK)
    ) u_bus3_reg (
        .clk     (clk),
        .reset   (reset),
        .wr_en   (wr_sel3),
        .wr_strb (wr_strb),
        .wr_data (wr_data),
        .value   (bus3_value)
    );

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign ar_take       = s_axi_arvalid && s_axi_arready;

    // read decode, whole word returned for any access size
    always @* begin
        rd_value = 32'h00000000;
        rd_hit   = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `SMCG_BUS1_OFFSET: rd_value = bus1_value;
            `SMCG_BUS2_OFFSET: rd_value = bus2_value;
            `SMCG_BUS3_OFFSET: rd_value = bus3_value;
            default:           rd_hit   = 1'b0;
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `SMCG_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= rd_hit ? `SMCG_RESP_OKAY : `SMCG_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // ----------------------------------------------------------------
    // sleep gating
    // ----------------------------------------------------------------
    // settings take effect on next sleep entry
    smcg_clock_gate #(
        .WIDTH (32)
    ) u_bus1_gate (
        .clk          (clk),
        .reset        (reset),
        .sleep_active (sleep_active),
        .enable_bits  (bus1_value),
        .clk_run      (bus1_run)
    );

    smcg_clock_gate #(
        .WIDTH (32)
    ) u_bus2_gate (
        .clk          (clk),
        .reset        (reset),
        .sleep_active (sleep_active),
        .enable_bits  (bus2_value),
        .clk_run      (bus2_run)
    );

    smcg_clock_gate #(
        .WIDTH (32)
    ) u_bus3_gate (
        .clk          (clk),
        .reset        (reset),
        .sleep_active (sleep_active),
        .enable_bits  (bus3_value),
        .clk_run      (bus3_run)
    );

    assign port_sleep_clk_on = bus1_run[`SMCG_B1_PORT_A +: `SMCG_B1_PORT_COUNT];

    assign checksum_sleep_clk_on   = bus1_run[`SMCG_B1_CHECKSUM];
    assign flash_if_sleep_clk_on   = bus1_run[`SMCG_B1_FLASH_IF];
    assign ram_bank1_sleep_clk_on  = bus1_run[`SMCG_B1_RAM_BANK1];
    assign ram_bank2_sleep_clk_on  = bus1_run[`SMCG_B1_RAM_BANK2];
    assign backup_ram_sleep_clk_on = bus1_run[`SMCG_B1_BACKUP_RAM];
    assign dma_unit1_sleep_clk_on  = bus1_run[`SMCG_B1_DMA_UNIT1];
    assign dma_unit2_sleep_clk_on  = bus1_run[`SMCG_B1_DMA_UNIT2];

    assign mac_sleep_clk_on           = bus1_run[`SMCG_B1_MAC];
    assign mac_transmit_sleep_clk_on  = bus1_run[`SMCG_B1_MAC_TX];
    assign mac_receive_sleep_clk_on   = bus1_run[`SMCG_B1_MAC_RX];
    assign mac_timestamp_sleep_clk_on = bus1_run[`SMCG_B1_MAC_TS];

    assign usb_highspeed_sleep_clk_on      = bus1_run[`SMCG_B1_USB_HS];
    assign usb_transceiver_if_sleep_clk_on = bus1_run[`SMCG_B1_USB_XCVR];

    assign camera_if_sleep_clk_on     = bus2_run[`SMCG_B2_CAMERA];
    assign float_unit_sleep_clk_on    = bus2_run[`SMCG_B2_FLOAT];
    assign cipher_sleep_clk_on        = bus2_run[`SMCG_B2_CIPHER];
    assign digest_sleep_clk_on        = bus2_run[`SMCG_B2_DIGEST];
    assign random_source_sleep_clk_on = bus2_run[`SMCG_B2_RANDOM];
    assign usb_fullspeed_sleep_clk_on = bus2_run[`SMCG_B2_USB_FS];

    assign ext_mem_ctrl_sleep_clk_on = bus3_run[`SMCG_B3_EXT_MEM];

endmodule

// ==== verification/smcg_assertions.sv ====
// concurrent checks on the sleep clock gating top ports
`timescale 1ns/1ps
`include "smcg_map.vh"
module smcg_assertions (
    input wire        clk,
    input wire        reset,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        sleep_active,
    input wire [8:0]  port_sleep_clk_on,
    input wire        checksum_sleep_clk_on,
    input wire        flash_if_sleep_clk_on,
    input wire        ram_bank1_sleep_clk_on,
    input wire        ram_bank2_sleep_clk_on,
    input wire        backup_ram_sleep_clk_on,
    input wire        dma_unit1_sleep_clk_on,
    input wire        dma_unit2_sleep_clk_on,
    input wire        mac_sleep_clk_on,
    input wire        mac_transmit_sleep_clk_on,
    input wire        mac_receive_sleep_clk_on,
    input wire        mac_timestamp_sleep_clk_on,
    input wire        usb_highspeed_sleep_clk_on,
    input wire        usb_transceiver_if_sleep_clk_on,
    input wire        camera_if_sleep_clk_on,
    input wire        float_unit_sleep_clk_on,
    input wire        cipher_sleep_clk_on,
    input wire        digest_sleep_clk_on,
    input wire        random_source_sleep_clk_on,
    input wire        usb_fullspeed_sleep_clk_on,
    input wire        ext_mem_ctrl_sleep_clk_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // all clock run requests in one vector
    wire [28:0] on_v = {port_sleep_clk_on, checksum_sleep_clk_on, flash_if_sleep_clk_on,
        ram_bank1_sleep_clk_on, ram_bank2_sleep_clk_on, backup_ram_sleep_clk_on,
        dma_unit1_sleep_clk_on, dma_unit2_sleep_clk_on, mac_sleep_clk_on,
        mac_transmit_sleep_clk_on, mac_receive_sleep_clk_on, mac_timestamp_sleep_clk_on,
        usb_highspeed_sleep_clk_on, usb_transceiver_if_sleep_clk_on, camera_if_sleep_clk_on,
        float_unit_sleep_clk_on, cipher_sleep_clk_on, digest_sleep_clk_on,
        random_source_sleep_clk_on, usb_fullspeed_sleep_clk_on, ext_mem_ctrl_sleep_clk_on};
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    // writable mask of a mapped offset, zero when unmapped
    function automatic [31:0] msk(input [7:0] a);
        msk = a == `SMCG_BUS1_OFFSET ? `SMCG_BUS1_MASK : a == `SMCG_BUS2_OFFSET ?
              `SMCG_BUS2_MASK : a == `SMCG_BUS3_OFFSET ? `SMCG_BUS3_MASK : 32'h00000000;
    endfunction

    a_awake_all_on: assert property (!sleep_active |=> &on_v)
        else $error("clock request low while awake");
    a_sleep_frozen: assert property (sleep_active ##1 sleep_active |=> $stable(on_v))
        else $error("clock requests moved during sleep");
    a_read_no_wait: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_resp: assert property (wr_hs |=> s_axi_bvalid && s_axi_bresp ==
        (msk($past(s_axi_awaddr)) != 0 ? `SMCG_RESP_OKAY : `SMCG_RESP_SLVERR))
        else $error("write response wrong or late");
    a_reserved_zero: assert property (ar_hs && msk(s_axi_araddr) != 0 |=>
        s_axi_rresp == `SMCG_RESP_OKAY && (s_axi_rdata & ~msk($past(s_axi_araddr))) == 0)
        else $error("reserved read bits not zero");
    a_unmapped_read: assert property (ar_hs && msk(s_axi_araddr) == 0 |=>
        s_axi_rresp == `SMCG_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read answer wrong");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before taken");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
endmodule
bind smcg_top smcg_assertions chk (.*);

// ==== verification/smcg_top_bench.sv ====
// self-checking bench for the sleep clock gating registers
`timescale 1ns/1ps
`include "smcg_map.vh"
module smcg_top_bench;
    reg         clk = 0, reset = 1, sleep_active = 0;
    reg  [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    reg  [31:0] s_axi_wdata = 0;
    reg  [3:0]  s_axi_wstrb = 0;
    reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg         s_axi_arvalid = 0, s_axi_rready = 0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, o1, o2, o3;
    int         err_count = 0, comparisons = 0, seed = 1597;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [31:0] m[3];
    logic [95:0] snap;
    localparam [95:0] ALL = {`SMCG_BUS1_MASK, `SMCG_BUS2_MASK, `SMCG_BUS3_MASK};

    // outputs land on their documented bit positions
    smcg_top dut (.clk, .reset, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sleep_active, .port_sleep_clk_on(o1[8:0]),
        .checksum_sleep_clk_on(o1[12]), .flash_if_sleep_clk_on(o1[15]),
        .ram_bank1_sleep_clk_on(o1[16]), .ram_bank2_sleep_clk_on(o1[17]),
        .backup_ram_sleep_clk_on(o1[18]), .dma_unit1_sleep_clk_on(o1[21]),
        .dma_unit2_sleep_clk_on(o1[22]), .mac_sleep_clk_on(o1[25]),
        .mac_transmit_sleep_clk_on(o1[26]), .mac_receive_sleep_clk_on(o1[27]),
        .mac_timestamp_sleep_clk_on(o1[28]), .usb_highspeed_sleep_clk_on(o1[29]),
        .usb_transceiver_if_sleep_clk_on(o1[30]), .camera_if_sleep_clk_on(o2[0]),
        .float_unit_sleep_clk_on(o2[1]), .cipher_sleep_clk_on(o2[4]),
        .digest_sleep_clk_on(o2[5]), .random_source_sleep_clk_on(o2[6]),
        .usb_fullspeed_sleep_clk_on(o2[7]), .ext_mem_ctrl_sleep_clk_on(o3[0]));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // -----------------------------
    // checking and reporting
    // -----------------------------
    task automatic close_out;
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic bad(input [95:0] g, input [95:0] e);
        err_count++;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
    endtask

    task automatic cmp_rd(input [33:0] g, input [33:0] e);
        comparisons++;
        if (g !== e) bad(g, e);
    endtask

    task automatic cmp_b(input [1:0] g, input [1:0] e);
        comparisons++;
        if (g !== e) bad(g, e);
    endtask

    // gate outputs, reserved slots masked away
    task automatic cmp_on(input [95:0] e);
        @(negedge clk);
        comparisons++;
        if (({o1, o2, o3} & ALL) !== e) bad({o1, o2, o3} & ALL, e);
    endtask

    // takes the oldest note whenever a response is handed over
    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready)
            if (rq.size() > 0) cmp_rd({s_axi_rresp, s_axi_rdata}, rq.pop_front());
            else bad({s_axi_rresp, s_axi_rdata}, 96'h0);
        if (s_axi_bvalid && s_axi_bready)
            if (bq.size() > 0) cmp_b(s_axi_bresp, bq.pop_front());
            else bad(s_axi_bresp, 96'h0);
    end

    // -----------------------------
    // bus master
    // -----------------------------
    function automatic int idx(input [7:0] a);
        return a == 8'h50 ? 0 : a == 8'h54 ? 1 : a == 8'h58 ? 2 : 3;
    endfunction

    task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input slow);
        int i, n;
        bit pa, pw, pb, ka, kw, kb, rb;
        i = idx(a);
        if (i < 3)
            for (int k = 0; k < 4; k++)
                if (s[k]) m[i][8*k+:8] = d[8*k+:8] & ALL[64-32*i+8*k+:8];
        bq.push_back(i < 3 ? 2'h0 : 2'h2);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        rb = !slow;
        s_axi_bready <= rb;
        {pa, pw, pb, n} = {3'b111, 32'd0};
        while (pb) begin
            @(negedge clk);
            {ka, kw, kb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge clk);
            if (pa && ka) begin pa = 0; s_axi_awvalid <= 0; end
            if (pw && kw) begin pw = 0; s_axi_wvalid <= 0; end
            if (kb && rb) begin pb = 0; s_axi_bready <= 0; end
            else if (kb) begin rb = 1; s_axi_bready <= 1; end
            if (++n > 40) begin err_count++; close_out(); end
        end
    endtask

    task automatic rd(input [7:0] a, input slow);
        int i, n;
        bit pa, pr, ka, kr, rr;
        i = idx(a);
        rq.push_back(i < 3 ? {2'h0, m[i]} : {2'h2, 32'h0});
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        rr = !slow;
        s_axi_rready <= rr;
        {pa, pr, n} = {2'b11, 32'd0};
        while (pr) begin
            @(negedge clk);
            {ka, kr} = {s_axi_arready, s_axi_rvalid};
            @(posedge clk);
            if (pa && ka) begin pa = 0; s_axi_arvalid <= 0; end
            if (kr && rr) begin pr = 0; s_axi_rready <= 0; end
            else if (kr) begin rr = 1; s_axi_rready <= 1; end
            if (++n > 40) begin err_count++; close_out(); end
        end
    endtask

    // sleep entry snapshots the registers one edge later
    task automatic slp(input v);
        @(posedge clk);
        sleep_active <= v;
        repeat (2) @(posedge clk);
        if (v) snap = {m[0], m[1], m[2]};
    endtask

    // -----------------------------
    // main sequence
    // -----------------------------
    initial begin
        logic [31:0] d;
        logic [3:0]  s;
        m = '{32'h7E6791FF, 32'h000000F1, 32'h00000001};
        repeat (2) @(posedge clk);
        reset <= 0;
        cmp_on(ALL);
        for (int j = 0; j < 3; j++) rd(8'h50 + 4 * j, j[0]);
        slp(1);
        cmp_on(snap);
        slp(0);
        for (int k = 0; k < 10; k++) begin
            for (int j = 0; j < 3; j++) begin
                d = k == 0 ? 32'h00000000 : k == 1 ? 32'hFFFFFFFF : $random(seed);
                s = k < 2 ? 4'hF : $random(seed);
                wr(8'h50 + 4 * j, d, s, k[0]);
                rd(8'h50 + 4 * j, k[1]);
            end
            cmp_on(ALL);
            slp(1);
            cmp_on(snap);
            wr(8'h50 + 4 * (k % 3), $random(seed), 4'hF, 0);
            cmp_on(snap);
            slp(0);
        end
        wr(8'h5C, 32'hFFFFFFFF, 4'hF, 1);
        rd(8'h5C, 0);
        rd(8'h4C, 1);
        repeat (2) @(posedge clk);
        close_out();
    end
endmodule
